// *** src/slc_link_regs.v ***
// Function
// - Multiframe length register holds K-1, reset 0x1F.
// - 64b/66b modes use K equal 256*E/F.
// - Writing 0 to sync bit requests sync.
// - Soft request works with every sync source while enabled; stuck pin needs source 2.
// - Mapping 0: lanes 0-3 active, others off.
// - Mapping 1: lanes 4-7 active, 0-3 off.
// - Sync source: pin, timestamp pin, or none.
// - Format bit: offset binary or two's complement.
// - Scrambler bit controls 8b/10b scrambling, default on.
// - 64b/66b modes always scramble.
// - Control resets 0x03, bits 7:5 reserved.
// - Test selector bits 4:0, reset 0x00.
// - Test codes: normal, PRBS, held low/high.
// - Disabled interface holds link logic in reset.
//
// Strobed register access was decided locally.
`include "slc_map.vh"

module slc_link_regs (
  input  wire                    ref_clk,
  input  wire                    arst_n,
  input  wire [`SLC_ADDR_W-1:0]  reg_addr,
  input  wire [7:0]              reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [7:0]              reg_rdata,
  input  wire                    dedicated_sync_pin_n,
  input  wire                    timestamp_pin_n,
  input  wire                    timestamp_receiver_enable,
  input  wire                    mode_is_64b66b,
  input  wire [4:0]              mode_e,
  input  wire [4:0]              mode_f,
  output reg                     serial_interface_enable,
  output reg  [7:0]              link_mode_select,
  output reg                     link_reset,
  output reg  [8:0]              effective_k,
  output reg                     sync_request,
  output reg  [7:0]              lane_power_a,
  output reg  [7:0]              lane_power_b,
  output reg                     sample_number_format,
  output reg                     scramble_active,
  output reg  [4:0]              test_mode_select,
  output reg  [2:0]              pattern_select,
  output reg                     serial_force_low,
  output reg                     serial_force_high
);

  reg  [7:0] multiframe_len_minus_one_reg;
  reg        soft_sync_request_n_reg;
  reg  [7:0] link_control_reg;
  reg  [7:0] link_test_control_reg;
  reg  [7:0] enable_reg;
  reg  [7:0] mode_reg;
  reg  [7:0] rdata_next;
  reg        pin_sync_n;
  reg  [8:0] k_next;
  wire [1:0] sync_sel;
  wire       upper_lane_mapping;
  wire       enabled;
  wire [4:0] test_code;

  // Lane enables for one link from the mapping bit; 4 lanes per half.
  function [7:0] slc_lanes;
    input alt;
    begin
      slc_lanes = alt ? `SLC_LANES_HIGH : `SLC_LANES_LOW;
    end
  endfunction

  // Only nine bits of K are kept; the legal link modes never need more.
  function [8:0] slc_k64;
    input [4:0] e;
    input [4:0] f;
    reg   [15:0] full;
    begin
      if (f == 5'h00) begin
        full = 16'h0000;
      end else begin
        full = ({11'h000, e} * `SLC_K64_NUM) / {11'h000, f};
      end
      slc_k64 = full[8:0];
    end
  endfunction

  // Matches one test-mode code; held-low and held-high both use it.
  function slc_code_is;
    input [4:0] code;
    input [4:0] want;
    begin
      slc_code_is = (code == want);
    end
  endfunction

  // Pattern generator select: 1, 2 and 3 pick the three PRBS lengths.
  function [2:0] slc_pattern;
    input [4:0] code;
    begin
      if (code == `SLC_TM_PRBS7) begin
        slc_pattern = 3'h1;
      end else if (code == `SLC_TM_PRBS15) begin
        slc_pattern = 3'h2;
      end else if (code == `SLC_TM_PRBS23) begin
        slc_pattern = 3'h3;
      end else begin
        slc_pattern = 3'h0;
      end
    end
  endfunction

  assign sync_sel           = link_control_reg[`SLC_CTRL_SSEL_HI:`SLC_CTRL_SSEL_LO];
  assign upper_lane_mapping = link_control_reg[`SLC_CTRL_ALT];
  assign enabled            = enable_reg[0];
  assign test_code          = link_test_control_reg[4:0];

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      multiframe_len_minus_one_reg <= `SLC_RST_KMLEN;
      soft_sync_request_n_reg      <= 1'b1;
      link_control_reg             <= `SLC_RST_CTRL;
      link_test_control_reg        <= `SLC_RST_TEST;
      enable_reg                   <= `SLC_RST_ENABLE;
      mode_reg                     <= `SLC_RST_MODE;
    end else if (reg_wr) begin
      // Writes are taken even while enabled; keeping them legal is up to software.
      if (reg_addr == `SLC_OFF_KMLEN) begin
        multiframe_len_minus_one_reg <= reg_wdata;
      end else if (reg_addr == `SLC_OFF_SYNC) begin
        soft_sync_request_n_reg <= reg_wdata[0];
      end else if (reg_addr == `SLC_OFF_CTRL) begin
        link_control_reg <= reg_wdata & `SLC_CTRL_MASK;
      end else if (reg_addr == `SLC_OFF_TEST) begin
        link_test_control_reg <= reg_wdata & `SLC_TEST_MASK;
      end else if (reg_addr == `SLC_OFF_ENABLE) begin
        enable_reg <= {7'h00, reg_wdata[0]};
      end else if (reg_addr == `SLC_OFF_MODE) begin
        mode_reg <= reg_wdata;
      end
    end
  end

  always @* begin
    if (reg_addr == `SLC_OFF_KMLEN) begin
      rdata_next = multiframe_len_minus_one_reg;
    end else if (reg_addr == `SLC_OFF_SYNC) begin
      rdata_next = {7'h00, soft_sync_request_n_reg};
    end else if (reg_addr == `SLC_OFF_CTRL) begin
      rdata_next = link_control_reg;
    end else if (reg_addr == `SLC_OFF_TEST) begin
      rdata_next = link_test_control_reg;
    end else if (reg_addr == `SLC_OFF_ENABLE) begin
      rdata_next = enable_reg;
    end else if (reg_addr == `SLC_OFF_MODE) begin
      rdata_next = mode_reg;
    end else if (reg_addr == `SLC_OFF_STATUS) begin
      rdata_next = {3'h0, link_reset, sync_request, scramble_active, 2'h0};
    end else begin
      rdata_next = 8'h00;
    end
  end

  always @* begin
    // The pin path is ignored when no pin is selected, so a stuck pin can be escaped.
    if (sync_sel == `SLC_SSEL_PIN) begin
      pin_sync_n = dedicated_sync_pin_n;
    end else if (sync_sel == `SLC_SSEL_TSPIN) begin
      pin_sync_n = timestamp_pin_n | ~timestamp_receiver_enable;
    end else begin
      pin_sync_n = 1'b1;
    end
  end

  always @* begin
    if (mode_is_64b66b) begin
      k_next = slc_k64(mode_e, mode_f);
    end else begin
      k_next = {1'b0, multiframe_len_minus_one_reg} + 9'h001;
    end
  end

  // Each output has a flop of its own, so no decode glitch reaches the link pins.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_interface_enable <= 1'b1;
    end else begin
      serial_interface_enable <= enabled;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_mode_select <= `SLC_RST_MODE;
    end else begin
      link_mode_select <= mode_reg;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_reset <= 1'b0;
    end else begin
      link_reset <= ~enabled;
    end
  end

  // K follows the register one cycle late, so it is settled before the link restarts.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      effective_k <= `SLC_RST_K;
    end else begin
      effective_k <= k_next;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_request <= 1'b0;
    end else if (enabled) begin
      sync_request <= ~soft_sync_request_n_reg | ~pin_sync_n;
    end else begin
      sync_request <= 1'b0;
    end
  end

  // Lanes stay powered down while the interface is off.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lane_power_a <= `SLC_LANES_LOW;
    end else if (enabled) begin
      lane_power_a <= slc_lanes(upper_lane_mapping);
    end else begin
      lane_power_a <= 8'h00;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lane_power_b <= `SLC_LANES_LOW;
    end else if (enabled) begin
      lane_power_b <= slc_lanes(upper_lane_mapping);
    end else begin
      lane_power_b <= 8'h00;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_number_format <= 1'b1;
    end else begin
      sample_number_format <= link_control_reg[`SLC_CTRL_FMT];
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scramble_active <= 1'b1;
    end else begin
      scramble_active <= mode_is_64b66b | link_control_reg[`SLC_CTRL_SCRAM];
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      test_mode_select <= `SLC_TM_NORMAL;
    end else begin
      test_mode_select <= test_code;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pattern_select <= 3'h0;
    end else begin
      pattern_select <= slc_pattern(test_code);
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_force_low <= 1'b0;
    end else if (enabled) begin
      serial_force_low <= slc_code_is(test_code, `SLC_TM_LOW);
    end else begin
      serial_force_low <= 1'b0;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_force_high <= 1'b0;
    end else if (enabled) begin
      serial_force_high <= slc_code_is(test_code, `SLC_TM_HIGH);
    end else begin
      serial_force_high <= 1'b0;
    end
  end

endmodule

// *** pkg/slc_map.vh ***
`ifndef SLC_MAP_VH
`define SLC_MAP_VH

`define SLC_ADDR_W          10
`define SLC_OFF_KMLEN       10'h202
`define SLC_OFF_SYNC        10'h203
`define SLC_OFF_CTRL        10'h204
`define SLC_OFF_TEST        10'h205
`define SLC_OFF_ENABLE      10'h200
`define SLC_OFF_MODE        10'h201
`define SLC_OFF_STATUS      10'h210

`define SLC_RST_KMLEN       8'h1F
`define SLC_RST_K           9'h020
`define SLC_LANES_LOW       8'h0F
`define SLC_LANES_HIGH      8'hF0
`define SLC_RST_SYNC        8'h01
`define SLC_RST_CTRL        8'h03
`define SLC_RST_TEST        8'h00
`define SLC_RST_ENABLE      8'h01
`define SLC_RST_MODE        8'h02

`define SLC_CTRL_SCRAM      0
`define SLC_CTRL_FMT        1
`define SLC_CTRL_SSEL_LO    2
`define SLC_CTRL_SSEL_HI    3
`define SLC_CTRL_ALT        4
`define SLC_CTRL_MASK       8'h1F
`define SLC_TEST_MASK       8'h1F

`define SLC_SSEL_PIN        2'h0
`define SLC_SSEL_TSPIN      2'h1
`define SLC_SSEL_NONE       2'h2

`define SLC_TM_NORMAL       5'h00
`define SLC_TM_PRBS7        5'h01
`define SLC_TM_PRBS15       5'h02
`define SLC_TM_PRBS23       5'h03
`define SLC_TM_LOW          5'h0A
`define SLC_TM_HIGH         5'h0B

`define SLC_K64_NUM         16'h0100

`endif

// *** verif/slc_link_regs_asserts.sv ***
module slc_chk (
  input logic       ref_clk,
  input logic       arst_n,
  input logic       mode_is_64b66b,
  input logic       serial_interface_enable,
  input logic       link_reset,
  input logic       sync_request,
  input logic       scramble_active,
  input logic       serial_force_low,
  input logic       serial_force_high,
  input logic [7:0] lane_power_a,
  input logic [4:0] mode_e,
  input logic [4:0] mode_f,
  input logic [4:0] test_mode_select,
  input logic [8:0] effective_k
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Two quiet cycles give the one-cycle output stage time to follow the enable bit.
  sequence s_off;
    !serial_interface_enable [*2];
  endsequence
  sequence s_m64;
    (mode_is_64b66b && mode_f != 5'h00) [*2];
  endsequence
  AST_LINK_RST: assert property (s_off |-> link_reset) else $error("link");
  AST_LANES_OFF: assert property (s_off |-> lane_power_a == 8'h00) else $error("lanes");
  AST_SYNC_OFF: assert property (s_off |-> !sync_request) else $error("sync");
  AST_FORCE_OFF: assert property (s_off |-> !serial_force_low) else $error("force");
  AST_SCR64: assert property (s_m64 |-> scramble_active) else $error("scramble");
  AST_K64: assert property (s_m64 ##0 $stable(mode_e) && $stable(mode_f)
    |-> effective_k == 16'h0100 * mode_e / mode_f) else $error("k");
  AST_FORCE_LO: assert property (serial_force_low |-> test_mode_select == 5'h0A)
    else $error("low");
  AST_FORCE_HI: assert property (serial_force_high |-> test_mode_select == 5'h0B)
    else $error("high");
endmodule

bind slc_link_regs slc_chk i_slc_chk (.ref_clk, .arst_n, .mode_is_64b66b, .serial_interface_enable,
  .link_reset, .sync_request, .scramble_active, .serial_force_low, .serial_force_high,
  .lane_power_a, .mode_e, .mode_f, .test_mode_select, .effective_k);

// *** verif/slc_rx_model.sv ***
module slc_rx_model (
  input  logic ref_clk,
  input  logic want_sync,
  input  logic ts_sync,
  output logic dedicated_sync_pin_n = 1'b1,
  output logic timestamp_pin_n = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // The receiver pulls its request line low and moves it only after an edge.
  always @(posedge ref_clk) begin
    dedicated_sync_pin_n <= !want_sync;
    timestamp_pin_n <= !ts_sync;
  end
endmodule

// *** verif/slc_link_regs_tb.sv ***
`include "slc_map.vh"
module slc_link_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, m64 = 1'b0;
  logic       want_sync = 1'b0, ts_sync = 1'b0, ts_en = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [4:0] mode_e = 5'h01, mode_f = 5'h02;
  logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h0A, 5'h0B};
  wire        pin_n, ts_n, sie, lrst, sreq, fmt, scrambler_enable, flo, fhi;
  wire  [7:0] rdata, lpa, lpb, lms;
  wire  [8:0] k;
  wire  [4:0] tms;
  wire  [2:0] pat;
  int         num_errors = 0;
  int         tests_run = 0;
  always #2.5 ref_clk = ~ref_clk;
  slc_rx_model i_slc_rx_model (.ref_clk, .want_sync, .ts_sync, .dedicated_sync_pin_n(pin_n),
    .timestamp_pin_n(ts_n));
  slc_link_regs i_slc_link_regs (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata(rdata), .dedicated_sync_pin_n(pin_n), .timestamp_pin_n(ts_n),
    .timestamp_receiver_enable(ts_en), .mode_is_64b66b(m64), .mode_e, .mode_f,
    .serial_interface_enable(sie), .link_mode_select(lms), .link_reset(lrst), .effective_k(k),
    .sync_request(sreq), .lane_power_a(lpa), .lane_power_b(lpb), .sample_number_format(fmt),
    .scramble_active(scrambler_enable), .test_mode_select(tms), .pattern_select(pat),
    .serial_force_low(flo), .serial_force_high(fhi));
  task automatic final_report;
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [8:0] e, logic [8:0] v);
    tests_run++;
    if (v !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(logic [9:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [9:0] a, logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  // Link settings written through cfg are touched only with the interface parked; the sync register is written live.
  task automatic cfg(logic [9:0] a, logic [7:0] d);
    wr(`SLC_OFF_ENABLE, 8'h00);
    wr(a, d);
    wr(`SLC_OFF_ENABLE, 8'h01);
    settle();
  endtask
  task automatic pins(logic ws, logic ts, logic te, logic m);
    @(posedge ref_clk);
    want_sync <= ws;
    ts_sync <= ts;
    ts_en <= te;
    m64 <= m;
    settle();
  endtask
  initial begin
    #200us;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(`SLC_OFF_KMLEN, 8'h1F);
    rd(`SLC_OFF_SYNC, 8'h01);
    rd(`SLC_OFF_CTRL, 8'h03);
    rd(`SLC_OFF_TEST, 8'h00);
    rd(10'h3FF, 8'h00);
    rd(`SLC_OFF_ENABLE, 8'h01);
    rd(`SLC_OFF_MODE, 8'h02);
    chk("mode", 9'h002, {1'b0, lms});
    chk("en_rst", 9'h002, {7'h00, sie, lrst});
    chk("k", 9'h020, k);
    cfg(`SLC_OFF_KMLEN, 8'h0F);
    chk("k", 9'h010, k);
    cfg(`SLC_OFF_CTRL, 8'hF0);
    rd(`SLC_OFF_CTRL, 8'h10);
    chk("lanes_a", 9'h0F0, {1'b0, lpa});
    chk("lanes_b", 9'h0F0, {1'b0, lpb});
    chk("fmt_scr", 9'h000, {fmt, scrambler_enable});
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    chk("k64", 9'h080, k);
    chk("scr64", 9'h001, {8'h00, scrambler_enable});
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    cfg(`SLC_OFF_CTRL, 8'h03);
    chk("lanes_a", 9'h00F, {1'b0, lpa});
    chk("lanes_b", 9'h00F, {1'b0, lpb});
    chk("fmt_scr", 9'h003, {fmt, scrambler_enable});
    wr(`SLC_OFF_SYNC, 8'h00);
    settle();
    chk("sreq", 9'h001, sreq);
    wr(`SLC_OFF_SYNC, 8'h01);
    settle();
    chk("sreq", 9'h000, sreq);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    chk("sreq", 9'h001, sreq);
    cfg(`SLC_OFF_CTRL, 8'h0B);
    chk("sreq", 9'h000, sreq);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    cfg(`SLC_OFF_CTRL, 8'h07);
    chk("sreq", 9'h001, sreq);
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    chk("sreq", 9'h000, sreq);
    foreach (codes[i]) begin
      cfg(`SLC_OFF_TEST, {3'b111, codes[i]});
      rd(`SLC_OFF_TEST, {3'b000, codes[i]});
      chk("pat", (codes[i] < 5'h04) ? codes[i] : 5'h00, pat);
      chk("tms", {4'h0, codes[i]}, {4'h0, tms});
      chk("force", {codes[i] == 5'h0A, codes[i] == 5'h0B}, {flo, fhi});
    end
    wr(`SLC_OFF_ENABLE, 8'h00);
    settle();
    chk("parked", 9'h100, {lrst, lpa});
    rd(`SLC_OFF_STATUS, 8'h14);
    final_report();
  end
endmodule
